// ### design/pfb_cfg.svh
// Offsets, field positions, reset values and timing counts of the blanking block
`ifndef PFB_CFG_SVH
`define PFB_CFG_SVH
`define PFB_OFF_LEB_CTRL 12'h000
`define PFB_OFF_LEB_DLY 12'h004
`define PFB_OFF_AUX 12'h008
`define PFB_OFF_STATUS 12'h00C
`define PFB_RST_LEB_CTRL 16'h0000
`define PFB_RST_LEB_DLY 16'h0000
`define PFB_RST_AUX 16'h0000
`define PFB_MASK_LEB_CTRL 16'hFC3F
`define PFB_MASK_LEB_DLY 16'h0FF8
`define PFB_MASK_AUX 16'hCF3F
`define PFB_B_HI_RISE 15
`define PFB_B_HI_FALL 14
`define PFB_B_LO_RISE 13
`define PFB_B_LO_FALL 12
`define PFB_B_FLT_LEB 11
`define PFB_B_CL_LEB 10
`define PFB_B_SRC_HI 5
`define PFB_B_SRC_LO 4
`define PFB_B_HS_HI 3
`define PFB_B_HS_LO 2
`define PFB_B_LS_HI 1
`define PFB_B_LS_LO 0
`define PFB_DLY_MSB 11
`define PFB_DLY_LSB 3
`define PFB_DLY_W 9
`define PFB_B_FINE_PER 15
`define PFB_B_FINE_DUTY 14
`define PFB_BSEL_MSB 11
`define PFB_BSEL_LSB 8
`define PFB_CSEL_MSB 5
`define PFB_CSEL_LSB 2
`define PFB_B_CHOP_H 1
`define PFB_B_CHOP_L 0
`define PFB_GEN_N 9
`define PFB_STEP_PS 8320
`define PFB_CLK_PS 4000
`define PFB_STEP_CYC ((`PFB_STEP_PS + `PFB_CLK_PS - 1) / `PFB_CLK_PS)
`endif

// ### design/pfb_pkg.sv
// Types shared by the blanking and chop block
package pfb_pkg;
   typedef logic [15:0] pfb_reg_t;
   typedef logic [3:0] pfb_sel_t;
   typedef enum logic [1:0]
   {
      PFB_RD_IDLE = 2'b00,
      PFB_RD_OK = 2'b01,
      PFB_RD_ERR = 2'b10
   } pfb_rsp_e;
endpackage : pfb_pkg

// ### design/pfb_edge_blank.sv
// Edge-triggered blanking counter with its own step divider
module pfb_edge_blank
   import pfb_pkg::*;
#(
   parameter int DLY_W = 9,
   parameter int STEP_CYC = 3
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic high_in,
   input wire logic low_in,
   input wire logic [3:0] trig_en,
   input wire logic [DLY_W-1:0] delay,
   output logic trig,
   output logic active
);
   localparam int DW = $clog2(STEP_CYC + 1);
   localparam logic [DW-1:0] STEP_LAST = DW'(STEP_CYC - 1);
   logic high_prev_reg;
   logic low_prev_reg;
   logic [DLY_W-1:0] cnt_reg;
   logic [DW-1:0] div_reg;

   // Previous output levels for edge detection
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         high_prev_reg <= 1'b0;
         low_prev_reg <= 1'b0;
      end
      else
      begin
         high_prev_reg <= high_in;
         low_prev_reg <= low_in;
      end
   end

   assign trig = (trig_en[3] & high_in & ~high_prev_reg)
      | (trig_en[2] & ~high_in & high_prev_reg)
      | (trig_en[1] & low_in & ~low_prev_reg)
      | (trig_en[0] & ~low_in & low_prev_reg);

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt_reg <= '0;
         div_reg <= '0;
      end
      else if (trig)
      begin
         cnt_reg <= delay;
         div_reg <= '0;
      end
      else if (cnt_reg != '0)
      begin
         if (div_reg == STEP_LAST)
         begin
            div_reg <= '0;
            cnt_reg <= cnt_reg - DLY_W'(1);
         end
         else
         begin
            div_reg <= div_reg + DW'(1);
         end
      end
   end

   assign active = (cnt_reg != '0);
endmodule : pfb_edge_blank

// ### design/pfb_top.sv
// Fault blanking, chop and fine-resolution gating for one PWM generator
`include "pfb_cfg.svh"
module pfb_top
   import pfb_pkg::*;
#(
   parameter int DLY_W = `PFB_DLY_W,
   parameter int STEP_CYC = `PFB_STEP_CYC,
   parameter int GEN_N = `PFB_GEN_N
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic pwm_high_in,
   input wire logic pwm_low_in,
   input wire logic [GEN_N-1:0] gen_high_in,
   input wire logic chop_clk_in,
   input wire logic fault_in,
   input wire logic current_limit_in,
   output logic high_side_output,
   output logic low_side_output,
   output logic chop_gate_signal,
   output logic fault_out,
   output logic current_limit_out,
   output logic fine_period_off,
   output logic fine_duty_off
);
   pfb_reg_t blanking_edge_and_state_control_reg;
   pfb_reg_t blanking_delay_reg;
   pfb_reg_t pwm_auxiliary_control_reg;
   pfb_reg_t wr_next;
   pfb_reg_t lane_mask;
   pfb_reg_t rd_next;
   pfb_rsp_e rsp_next;
   logic [31:0] prdata_reg;
   logic pready_reg;
   logic pslverr_reg;
   logic apb_setup;
   logic apb_write;
   logic [DLY_W-1:0] blank_delay_count;
   pfb_sel_t state_blank_source_select;
   pfb_sel_t chop_source_select;
   logic state_src;
   logic chop_src;
   logic leb_trig;
   logic leb_active;
   logic state_mask;
   logic fault_edge_blank_en;
   logic current_limit_edge_blank_en;
   logic high_side_chop_en;
   logic low_side_chop_en;
   logic fault_mask;
   logic cl_mask;

   // Bus phases; the access phase always finishes in one cycle
   assign apb_setup = psel & ~penable;
   assign apb_write = psel & penable & pready_reg & pwrite & ~pslverr_reg;
   assign lane_mask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
   assign wr_next = pwdata[15:0] & lane_mask;

   // Read mux and address decode
   always_comb
   begin
      rd_next = 16'h0000;
      rsp_next = PFB_RD_OK;
      unique case (paddr)
         `PFB_OFF_LEB_CTRL: rd_next = blanking_edge_and_state_control_reg;
         `PFB_OFF_LEB_DLY: rd_next = blanking_delay_reg;
         `PFB_OFF_AUX: rd_next = pwm_auxiliary_control_reg;
         `PFB_OFF_STATUS: rd_next = {13'h0000, chop_src, state_mask, leb_active};
         default: rsp_next = PFB_RD_ERR;
      endcase
   end

   // Answer registers loaded in the setup phase
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata_reg <= 32'h00000000;
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
      end
      else
      begin
         pready_reg <= apb_setup;
         pslverr_reg <= apb_setup & (rsp_next == PFB_RD_ERR);
         if (apb_setup & ~pwrite)
         begin
            prdata_reg <= {16'h0000, rd_next};
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         blanking_edge_and_state_control_reg <= `PFB_RST_LEB_CTRL;
         blanking_delay_reg <= `PFB_RST_LEB_DLY;
         pwm_auxiliary_control_reg <= `PFB_RST_AUX;
      end
      else if (apb_write)
      begin
         if (paddr == `PFB_OFF_LEB_CTRL)
         begin
            blanking_edge_and_state_control_reg <= ((blanking_edge_and_state_control_reg
               & ~lane_mask) | wr_next) & `PFB_MASK_LEB_CTRL;
         end
         if (paddr == `PFB_OFF_LEB_DLY)
         begin
            blanking_delay_reg <= ((blanking_delay_reg & ~lane_mask) | wr_next)
               & `PFB_MASK_LEB_DLY;
         end
         if (paddr == `PFB_OFF_AUX)
         begin
            pwm_auxiliary_control_reg <= ((pwm_auxiliary_control_reg & ~lane_mask)
               | wr_next) & `PFB_MASK_AUX;
         end
      end
   end

   // Field extraction
   assign blank_delay_count = blanking_delay_reg[`PFB_DLY_MSB:`PFB_DLY_LSB];
   assign state_blank_source_select = pwm_auxiliary_control_reg[`PFB_BSEL_MSB:`PFB_BSEL_LSB];
   assign chop_source_select = pwm_auxiliary_control_reg[`PFB_CSEL_MSB:`PFB_CSEL_LSB];
   assign fault_edge_blank_en = blanking_edge_and_state_control_reg[`PFB_B_FLT_LEB];
   assign current_limit_edge_blank_en = blanking_edge_and_state_control_reg[`PFB_B_CL_LEB];
   assign high_side_chop_en = pwm_auxiliary_control_reg[`PFB_B_CHOP_H];
   assign low_side_chop_en = pwm_auxiliary_control_reg[`PFB_B_CHOP_L];

   always_comb
   begin
      state_src = 1'b0;
      chop_src = chop_clk_in;
      if ((state_blank_source_select != 4'h0) && (state_blank_source_select <= GEN_N))
      begin
         state_src = gen_high_in[state_blank_source_select - 4'h1];
      end
      if (chop_source_select != 4'h0)
      begin
         chop_src = 1'b0;
         if (chop_source_select <= GEN_N)
         begin
            chop_src = gen_high_in[chop_source_select - 4'h1];
         end
      end
   end

   // Edge blanking counter
   pfb_edge_blank #(
      .DLY_W(DLY_W),
      .STEP_CYC(STEP_CYC)
   ) u_edge_blank (
      .clk(pclk),
      .rst_n(presetn),
      .high_in(pwm_high_in),
      .low_in(pwm_low_in),
      .trig_en(blanking_edge_and_state_control_reg[`PFB_B_HI_RISE:`PFB_B_LO_FALL]),
      .delay(blank_delay_count),
      .trig(leb_trig),
      .active(leb_active)
   );

   assign state_mask =
      (blanking_edge_and_state_control_reg[`PFB_B_SRC_HI] & (state_blank_source_select != 4'h0)
         & state_src)
      | (blanking_edge_and_state_control_reg[`PFB_B_SRC_LO] & (state_blank_source_select != 4'h0)
         & ~state_src)
      | (blanking_edge_and_state_control_reg[`PFB_B_HS_HI] & pwm_high_in)
      | (blanking_edge_and_state_control_reg[`PFB_B_HS_LO] & ~pwm_high_in)
      | (blanking_edge_and_state_control_reg[`PFB_B_LS_HI] & pwm_low_in)
      | (blanking_edge_and_state_control_reg[`PFB_B_LS_LO] & ~pwm_low_in);

   // blanking gated by the input enables
   assign fault_mask = fault_edge_blank_en & (leb_active | state_mask);
   assign cl_mask = current_limit_edge_blank_en & (leb_active | state_mask);

   // Masked fault and current-limit outputs
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         fault_out <= 1'b0;
         current_limit_out <= 1'b0;
      end
      else
      begin
         fault_out <= fault_in & ~fault_mask;
         current_limit_out <= current_limit_in & ~cl_mask;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         high_side_output <= 1'b0;
         low_side_output <= 1'b0;
         chop_gate_signal <= 1'b0;
      end
      else
      begin
         high_side_output <= pwm_high_in & (~high_side_chop_en | chop_src);
         low_side_output <= pwm_low_in & (~low_side_chop_en | chop_src);
         chop_gate_signal <= chop_src;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         fine_period_off <= 1'b0;
         fine_duty_off <= 1'b0;
      end
      else
      begin
         fine_period_off <= pwm_auxiliary_control_reg[`PFB_B_FINE_PER];
         fine_duty_off <= pwm_auxiliary_control_reg[`PFB_B_FINE_DUTY];
      end
   end

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;

   // Checks on blanking, selection and register behaviour
   a_high_rise: assert property (
      @(posedge pclk) disable iff (!presetn)
      (blanking_edge_and_state_control_reg[`PFB_B_HI_RISE] && $rose(pwm_high_in)
         && blank_delay_count != '0) |=> leb_active)
      else $error("high rise did not start blanking");
   a_high_fall: assert property (
      @(posedge pclk) disable iff (!presetn)
      (blanking_edge_and_state_control_reg[`PFB_B_HI_FALL] && $fell(pwm_high_in)
         && blank_delay_count != '0) |=> leb_active)
      else $error("high fall did not start blanking");
   a_low_rise: assert property (
      @(posedge pclk) disable iff (!presetn)
      (blanking_edge_and_state_control_reg[`PFB_B_LO_RISE] && $rose(pwm_low_in)
         && blank_delay_count != '0) |=> leb_active)
      else $error("low rise did not start blanking");
   a_low_fall: assert property (
      @(posedge pclk) disable iff (!presetn)
      (blanking_edge_and_state_control_reg[`PFB_B_LO_FALL] && $fell(pwm_low_in)
         && blank_delay_count != '0) |=> leb_active)
      else $error("low fall did not start blanking");
   a_fault_pass: assert property (
      @(posedge pclk) disable iff (!presetn)
      !fault_edge_blank_en |=> fault_out == $past(fault_in))
      else $error("fault input masked while blanking disabled");
   a_cl_blank: assert property (
      @(posedge pclk) disable iff (!presetn)
      (current_limit_edge_blank_en && leb_active) |=> !current_limit_out)
      else $error("current limit passed during edge blanking");
   a_blank_len: assert property (
      @(posedge pclk) disable iff (!presetn)
      (leb_trig && blank_delay_count == 9'h001) ##1 (!leb_trig)[*3]
         |-> leb_active ##1 !leb_active)
      else $error("one blanking step is not three cycles");
   a_src_high: assert property (
      @(posedge pclk) disable iff (!presetn)
      (blanking_edge_and_state_control_reg[`PFB_B_SRC_HI] && state_src && fault_edge_blank_en)
         |=> !fault_out)
      else $error("fault passed while source high blanking");
   a_src_low: assert property (
      @(posedge pclk) disable iff (!presetn)
      (blanking_edge_and_state_control_reg[`PFB_B_SRC_LO] && !state_src
         && state_blank_source_select != 4'h0 && current_limit_edge_blank_en)
         |=> !current_limit_out)
      else $error("current limit passed while source low blanking");
   a_hs_state: assert property (
      @(posedge pclk) disable iff (!presetn)
      ((blanking_edge_and_state_control_reg[`PFB_B_HS_HI] && pwm_high_in)
         || (blanking_edge_and_state_control_reg[`PFB_B_HS_LO] && !pwm_high_in)) |-> state_mask)
      else $error("high side state blanking missing");
   a_ls_state: assert property (
      @(posedge pclk) disable iff (!presetn)
      ((blanking_edge_and_state_control_reg[`PFB_B_LS_HI] && pwm_low_in)
         || (blanking_edge_and_state_control_reg[`PFB_B_LS_LO] && !pwm_low_in)) |-> state_mask)
      else $error("low side state blanking missing");
   a_src_none: assert property (
      @(posedge pclk) disable iff (!presetn)
      state_blank_source_select == 4'h0 |-> !state_src)
      else $error("source code zero is not constant low");
   a_chop_high: assert property (
      @(posedge pclk) disable iff (!presetn)
      (high_side_chop_en && chop_source_select == 4'h0 && pwm_high_in)
         |=> high_side_output == $past(chop_clk_in))
      else $error("high side not chopped by chop generator");
   a_chop_low: assert property (
      @(posedge pclk) disable iff (!presetn)
      (!low_side_chop_en) |=> low_side_output == $past(pwm_low_in))
      else $error("low side chopped while chop disabled");
   a_fine_off: assert property (
      @(posedge pclk) disable iff (!presetn)
      (apb_write && paddr == `PFB_OFF_AUX && pstrb[1]) |=> ##1
         (fine_period_off == $past(pwdata[15], 2) && fine_duty_off == $past(pwdata[14], 2)))
      else $error("fine resolution gating did not follow write");
   a_rsvd_zero: assert property (
      @(posedge pclk) disable iff (!presetn)
      (pready_reg && !pwrite && paddr == `PFB_OFF_LEB_DLY)
         |-> (prdata_reg[31:12] == 20'h00000 && prdata_reg[2:0] == 3'h0))
      else $error("reserved delay bits read nonzero");
   a_retrig: assert property (
      @(posedge pclk) disable iff (!presetn)
      (leb_trig && blank_delay_count != '0) ##1 (!leb_trig)[*2]
         |-> ($past(leb_active) && leb_active) ##1 leb_active)
      else $error("trigger did not hold blanking three cycles");
   a_mask_or: assert property (
      @(posedge pclk) disable iff (!presetn)
      (fault_edge_blank_en && !leb_active && !state_mask) |=> fault_out == $past(fault_in))
      else $error("fault masked with no blanking active");
endmodule : pfb_top

// ### dv/pfb_stage_model.sv
// Power stage pair and sibling generator outputs seen by the blanking block
module pfb_stage_model
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [7:0] period,
   output logic high_out,
   output logic low_out,
   output logic [8:0] sib_high,
   output logic chop_clk
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [8:0] cnt_reg;

   // Complementary pair with a dead cycle, rotating siblings, divided chop clock
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt_reg <= 9'h000;
         high_out <= 1'b0;
         low_out <= 1'b0;
         sib_high <= 9'h000;
         chop_clk <= 1'b0;
      end
      else
      begin
         cnt_reg <= (cnt_reg >= {period, 1'b0}) ? 9'h000 : cnt_reg + 9'h001;
         high_out <= (cnt_reg != 9'h000) && (cnt_reg < {1'b0, period});
         low_out <= cnt_reg > {1'b0, period};
         sib_high <= {sib_high[7:0], ~sib_high[8]};
         chop_clk <= cnt_reg[1];
      end
   end
endmodule : pfb_stage_model

// ### dv/testbench.sv
// Self-checking bench for the blanking, chop and fine-resolution gating block
`include "pfb_cfg.svh"
module testbench
   import pfb_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int STEP = 3;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] pstrb = 4'h0;
   logic [31:0] prdata;
   logic pready, pslverr, pwm_high_in, pwm_low_in, chop_clk_in;
   logic fault_in = 1'b0;
   logic current_limit_in = 1'b0;
   logic [8:0] gen_high_in;
   logic high_side_output, low_side_output, chop_gate_signal, fault_out;
   logic current_limit_out, fine_period_off, fine_duty_off;
   logic [7:0] per = 8'h10;
   integer seed = 32'hffaf;
   int fails = 0;
   int samples_checked = 0;
   logic [31:0] rv, rv_f, rd;
   logic err, src_m, sb_m, bl_m, chop_m, trig_m, ph_m, pl_m;
   logic [15:0] ctrl_m, dly_m, aux_m;
   logic [3:0] cs_m, bs_m, c;
   logic [6:0] exp_m, exp_c;
   int cnt_m;
   logic [11:0] offs [3] = '{`PFB_OFF_LEB_CTRL, `PFB_OFF_LEB_DLY, `PFB_OFF_AUX};
   logic [15:0] msk [3] = '{`PFB_MASK_LEB_CTRL, `PFB_MASK_LEB_DLY, `PFB_MASK_AUX};

   always #2 pclk = ~pclk;

   pfb_top #(.STEP_CYC(STEP)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .pwm_high_in(pwm_high_in),
      .pwm_low_in(pwm_low_in), .gen_high_in(gen_high_in), .chop_clk_in(chop_clk_in),
      .fault_in(fault_in), .current_limit_in(current_limit_in),
      .high_side_output(high_side_output), .low_side_output(low_side_output),
      .chop_gate_signal(chop_gate_signal), .fault_out(fault_out),
      .current_limit_out(current_limit_out), .fine_period_off(fine_period_off),
      .fine_duty_off(fine_duty_off));

   pfb_stage_model u_stage (.clk(pclk), .rst_n(presetn), .period(per),
      .high_out(pwm_high_in), .low_out(pwm_low_in), .sib_high(gen_high_in),
      .chop_clk(chop_clk_in));

   // Random fault and current-limit activity
   always @(posedge pclk)
   begin
      rv_f = $random(seed);
      fault_in <= rv_f[0];
      current_limit_in <= rv_f[1];
   end

   // Register merge honouring byte lanes and implemented bits
   function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] keep);
      logic [15:0] m;
      m = {{8{pstrb[1]}}, {8{pstrb[0]}}} & keep;
      return (old & ~m) | (pwdata[15:0] & m);
   endfunction : merge

   // Reference model: next outputs from inputs and register copies at each edge
   always @(posedge pclk)
   begin
      if (presetn !== 1'b1)
      begin
         {ctrl_m, dly_m, aux_m, exp_m, ph_m, pl_m} = '0;
         cnt_m = 0;
      end
      else
      begin
         cs_m = aux_m[5:2];
         bs_m = aux_m[11:8];
         chop_m = (cs_m == 0) ? chop_clk_in : (cs_m <= 9) ? gen_high_in[cs_m - 1] : 1'b0;
         src_m = (bs_m != 0 && bs_m <= 9) ? gen_high_in[bs_m - 1] : 1'b0;
         sb_m = (ctrl_m[5] & src_m) | (ctrl_m[4] & ~src_m & (bs_m != 0))
            | (ctrl_m[3] & pwm_high_in) | (ctrl_m[2] & ~pwm_high_in)
            | (ctrl_m[1] & pwm_low_in) | (ctrl_m[0] & ~pwm_low_in);
         bl_m = (cnt_m > 0) | sb_m;
         exp_m[6] = pwm_high_in & (~aux_m[1] | chop_m);
         exp_m[5] = pwm_low_in & (~aux_m[0] | chop_m);
         exp_m[4] = chop_m;
         exp_m[3] = fault_in & ~(ctrl_m[11] & bl_m);
         exp_m[2] = current_limit_in & ~(ctrl_m[10] & bl_m);
         exp_m[1:0] = aux_m[15:14];
         trig_m = (ctrl_m[15] & pwm_high_in & ~ph_m) | (ctrl_m[14] & ~pwm_high_in & ph_m)
            | (ctrl_m[13] & pwm_low_in & ~pl_m) | (ctrl_m[12] & ~pwm_low_in & pl_m);
         cnt_m = trig_m ? dly_m[11:3] * STEP : (cnt_m > 0) ? cnt_m - 1 : 0;
         ph_m = pwm_high_in;
         pl_m = pwm_low_in;
         if (psel && penable && pready === 1'b1 && pwrite)
         begin
            case (paddr)
               `PFB_OFF_LEB_CTRL: ctrl_m = merge(ctrl_m, `PFB_MASK_LEB_CTRL);
               `PFB_OFF_LEB_DLY: dly_m = merge(dly_m, `PFB_MASK_LEB_DLY);
               `PFB_OFF_AUX: aux_m = merge(aux_m, `PFB_MASK_AUX);
               default: ;
            endcase
         end
      end
   end

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         fails++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   // Outputs compared against the model mid-cycle, once settled; reset clears them at once
   always @(negedge pclk)
   begin
      exp_c = (presetn === 1'b1) ? exp_m : 7'h00;
      check("high_side_output", high_side_output, exp_c[6]);
      check("low_side_output", low_side_output, exp_c[5]);
      check("chop_gate_signal", chop_gate_signal, exp_c[4]);
      check("fault_out", fault_out, exp_c[3]);
      check("current_limit_out", current_limit_out, exp_c[2]);
      check("fine_period_off", fine_period_off, exp_c[1]);
      check("fine_duty_off", fine_duty_off, exp_c[0]);
   end

   // One bus transfer, held until pready is sampled high
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
      input logic [3:0] s);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      // Only the watchdog ends a wait that never sees pready
      do
      begin
         @(posedge pclk);
      end
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rd_reg(input logic [11:0] a, input logic [31:0] e, input string n);
      apb(1'b0, a, 32'h0, 4'h0);
      check(n, rd, e);
   endtask : rd_reg

   task automatic test_done;
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : test_done

   // Hang guard
   initial
   begin
      #300000;
      fails++;
      test_done();
   end

   // Main sequence
   initial
   begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 3; i++)
         rd_reg(offs[i], 32'h0, "reset value");
      for (int i = 0; i < 3; i++)
      begin
         apb(1'b1, offs[i], 32'hFFFFFFFF, 4'hF);
         rd_reg(offs[i], {16'h0, msk[i]}, "implemented bits");
         apb(1'b1, offs[i], 32'h0, 4'hF);
      end
      $display("test registers done");
      apb(1'b1, 12'h010, 32'hFFFF, 4'hF);
      check("unmapped write error", {31'h0, err}, 32'h1);
      apb(1'b0, 12'h010, 32'h0, 4'h0);
      check("unmapped read error", {31'h0, err}, 32'h1);
      check("unmapped read data", rd, 32'h0);
      $display("test unmapped done");
      for (int i = 0; i < 40; i++)
      begin
         rv = $random(seed);
         // Codes 10 to 15 select no source for both blanking and chopping
         c = 4'(i % 16);
         per <= rv[7:0] | 8'h04;
         apb(1'b1, `PFB_OFF_LEB_CTRL, rv, rv[23:20]);
         apb(1'b1, `PFB_OFF_LEB_DLY, {16'h0, rv[31], 8'h0, rv[27:24], rv[30:28]}, 4'hF);
         apb(1'b1, `PFB_OFF_AUX, {16'h0, rv[15:14], 2'b11, c, 2'b11, 4'd9 - c, rv[1:0]}, 4'h3);
         repeat (150) @(posedge pclk);
      end
      $display("test random configurations done");
      per <= 8'hFF;
      apb(1'b1, `PFB_OFF_LEB_CTRL, 32'h8C00, 4'hF);
      apb(1'b1, `PFB_OFF_LEB_DLY, 32'h0FF8, 4'hF);
      repeat (1700) @(posedge pclk);
      apb(1'b1, `PFB_OFF_LEB_DLY, 32'h0, 4'hF);
      repeat (600) @(posedge pclk);
      $display("test delay boundaries done");
      presetn <= 1'b0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      rd_reg(`PFB_OFF_LEB_CTRL, 32'h0, "value after reset");
      // Status after reset: no edge or state blanking, chop bit free running
      apb(1'b0, `PFB_OFF_STATUS, 32'h0, 4'h0);
      check("status blanking bits", rd & 32'hFFFFFFFB, 32'h0);
      check("status read error", {31'h0, err}, 32'h0);
      $display("test second reset done");
      test_done();
   end
endmodule : testbench
